/* File: design/scl_pkg.sv */
// Functional notes
// - divide select 00,01,10,11 gives 2,4,8,1
// - slow request divides output by sixteen synchronously
// - reference select high picks crystal, else external
// - output enable active high, glitch free gating
// - disabled output holds true low, complement high
// - shift chain captures data on shift clock rise
// - serial strobe high makes latches follow chain, loop and divide only while parallel strobe high
// - parallel strobe low makes latches follow inputs
// - seven bit loop divider, bit six MSB
// - two bit divide select taken from parallel inputs
// - diagnostic output chosen by serial three bit field
// - open serial pins and external reference read low
// - open parallel and control pins read high, slow request and crystal pins low
package scl_pkg;

  // ==========================================================
  // configuration fields
  localparam int LOOP_W = 7;
  localparam int DIV_W = 2;
  localparam int DIAG_W = 3;
  localparam int CHAIN_W = 12;
  localparam int CNT_W = 8;

  typedef struct packed {
    logic [DIAG_W-1:0] diag;
    logic [DIV_W-1:0] div_sel;
    logic [LOOP_W-1:0] loop_div;
  } scl_cfg_type;

  localparam scl_cfg_type CFG_RESET = '{diag: 3'h0, div_sel: 2'h3, loop_div: 7'h7f};

  // ==========================================================
  // configuration and control pins
  typedef struct packed {
    logic serial_latch_strobe;
    logic serial_config_in;
    logic serial_shift_clock;
    logic external_reference_in;
    logic parallel_latch_strobe_n;
    logic [LOOP_W-1:0] loop_divide_value;
    logic [DIV_W-1:0] output_divide_select;
    logic output_drive_enable;
    logic reference_source_select;
    logic slow_output_request;
    logic crystal_osc_pins;
  } scl_pins_type;

  // level seen on a pin that is left open
  localparam scl_pins_type PULL_LEVEL = '{
    serial_latch_strobe: 1'b0, serial_config_in: 1'b0, serial_shift_clock: 1'b0,
    external_reference_in: 1'b0, parallel_latch_strobe_n: 1'b1,
    loop_divide_value: 7'h7f, output_divide_select: 2'h3, output_drive_enable: 1'b1,
    reference_source_select: 1'b1, slow_output_request: 1'b0, crystal_osc_pins: 1'b0};

  // ==========================================================
  // output divider
  localparam logic [DIV_W-1:0] DIV_CODE_2 = 2'h0;
  localparam logic [DIV_W-1:0] DIV_CODE_4 = 2'h1;
  localparam logic [DIV_W-1:0] DIV_CODE_8 = 2'h2;
  localparam logic [CNT_W-1:0] HALF_1 = 8'h01;
  localparam logic [CNT_W-1:0] HALF_2 = 8'h02;
  localparam logic [CNT_W-1:0] HALF_4 = 8'h04;
  localparam logic [CNT_W-1:0] HALF_8 = 8'h08;
  localparam logic [CNT_W-1:0] SLOW_FACTOR = 8'h10;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  typedef enum logic [DIAG_W-1:0] {
    DIAG_LOW = 3'h0,
    DIAG_REF = 3'h1,
    DIAG_VCO = 3'h2,
    DIAG_OUT = 3'h3,
    DIAG_CHAIN = 3'h4,
    DIAG_HIGH = 3'h5
  } scl_diag_type;

  // ==========================================================
  // register map
  localparam int AXI_AW = 8;
  localparam logic [AXI_AW-1:0] ADDR_MASK = 8'hfc;
  localparam logic [AXI_AW-1:0] ADDR_STATUS = 8'h00;
  localparam logic [AXI_AW-1:0] ADDR_CONTROL = 8'h04;
  localparam logic [AXI_AW-1:0] ADDR_CHAIN = 8'h08;
  localparam int STAT_OE_BIT = 12;
  localparam int STAT_SLOW_BIT = 13;
  localparam int STAT_PHASE_BIT = 14;
  localparam int CTRL_DIS_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: design/scl_synth_config.sv */
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module scl_synth_config
  import scl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire scl_pins_type pins,
  input wire scl_pins_type pins_driven,
  input wire logic vco_tick,
  output logic synth_out_p,
  output logic synth_out_n,
  output logic diagnostic_out,
  output logic pll_reference_out,
  output logic [LOOP_W-1:0] loop_divide_out,
  input wire logic [AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // pin resolution
  scl_pins_type pin_r;
  logic sclk_prev_ff;
  logic shift_rise;
  logic [CHAIN_W-1:0] chain_ff;
  scl_cfg_type chain_cfg;
  scl_cfg_type cfg_ff;
  scl_cfg_type nxt_cfg;

  // open pins fall back to their pull level
  assign pin_r = scl_pins_type'((pins & pins_driven) | (PULL_LEVEL & ~pins_driven));

  // ==========================================================
  // serial chain and configuration latches
  assign shift_rise = pin_r.serial_shift_clock & ~sclk_prev_ff;
  assign chain_cfg = scl_cfg_type'(chain_ff);

  // parallel strobe owns loop and divide fields, diag comes only from the chain
  assign nxt_cfg.loop_div = !pin_r.parallel_latch_strobe_n ? pin_r.loop_divide_value :
                            pin_r.serial_latch_strobe ? chain_cfg.loop_div :
                            cfg_ff.loop_div;
  assign nxt_cfg.div_sel = !pin_r.parallel_latch_strobe_n ? pin_r.output_divide_select :
                           pin_r.serial_latch_strobe ? chain_cfg.div_sel :
                           cfg_ff.div_sel;
  assign nxt_cfg.diag = pin_r.serial_latch_strobe ? chain_cfg.diag : cfg_ff.diag;

  // shift left, newest bit at the bottom
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sclk_prev_ff <= 1'b0;
      chain_ff <= '0;
      cfg_ff <= CFG_RESET;
    end
    else
    begin
      sclk_prev_ff <= pin_r.serial_shift_clock;
      if (shift_rise)
      begin
        chain_ff <= {chain_ff[CHAIN_W-2:0], pin_r.serial_config_in};
      end
      cfg_ff <= nxt_cfg;
    end
  end

  assign loop_divide_out = cfg_ff.loop_div;

  // ==========================================================
  // output divider and synchronous gating
  logic [CNT_W-1:0] half_base;
  logic [CNT_W-1:0] half_lim;
  logic [CNT_W-1:0] edge_cnt_ff;
  logic wrap;
  logic phase_ff;
  logic slow_ff;
  logic oe_sync_ff;
  logic ctrl_dis_ff;
  logic gated;

  // half period in vco edges per divide code
  assign half_base = (cfg_ff.div_sel == DIV_CODE_2) ? HALF_2 :
                     (cfg_ff.div_sel == DIV_CODE_4) ? HALF_4 :
                     (cfg_ff.div_sel == DIV_CODE_8) ? HALF_8 : HALF_1;
  assign half_lim = slow_ff ? CNT_W'(half_base * SLOW_FACTOR) : half_base;
  assign wrap = vco_tick && (edge_cnt_ff >= CNT_W'(half_lim - CNT_ONE));
  assign gated = phase_ff & oe_sync_ff;

  // slow request switches only at a half period boundary
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      edge_cnt_ff <= '0;
      phase_ff <= 1'b0;
      slow_ff <= 1'b0;
    end
    else if (wrap)
    begin
      edge_cnt_ff <= '0;
      phase_ff <= ~phase_ff;
      slow_ff <= pin_r.slow_output_request;
    end
    else if (vco_tick)
    begin
      edge_cnt_ff <= CNT_W'(edge_cnt_ff + CNT_ONE);
    end
  end

  // enable changes only while the divided phase is low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      oe_sync_ff <= 1'b0;
      synth_out_p <= 1'b0;
      synth_out_n <= 1'b1;
    end
    else
    begin
      if (!phase_ff)
      begin
        oe_sync_ff <= pin_r.output_drive_enable & ~ctrl_dis_ff;
      end
      synth_out_p <= gated;
      synth_out_n <= ~gated;
    end
  end

  // ==========================================================
  // reference select and diagnostic output
  logic diag_mux;

  assign diag_mux = (cfg_ff.diag == DIAG_REF) ? pll_reference_out :
                    (cfg_ff.diag == DIAG_VCO) ? vco_tick :
                    (cfg_ff.diag == DIAG_OUT) ? phase_ff :
                    (cfg_ff.diag == DIAG_CHAIN) ? chain_ff[CHAIN_W-1] :
                    (cfg_ff.diag == DIAG_HIGH);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pll_reference_out <= 1'b0;
      diagnostic_out <= 1'b0;
    end
    else
    begin
      pll_reference_out <= pin_r.reference_source_select ? pin_r.crystal_osc_pins :
                           pin_r.external_reference_in;
      diagnostic_out <= diag_mux;
    end
  end

  // ==========================================================
  // axi4-lite register slave
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [AXI_AW-1:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic w_strb0_ff;
  logic do_write;
  logic wr_ctrl;
  logic [AXI_AW-1:0] rd_addr;
  logic [31:0] rd_word;
  logic rd_hit;

  assign do_write = aw_hold_ff && w_hold_ff && !s_axi_bvalid;
  assign wr_ctrl = (aw_addr_ff & ADDR_MASK) == ADDR_CONTROL;
  assign rd_addr = s_axi_araddr & ADDR_MASK;
  assign rd_hit = (rd_addr == ADDR_STATUS) || (rd_addr == ADDR_CONTROL) ||
                  (rd_addr == ADDR_CHAIN);
  assign rd_word = (rd_addr == ADDR_STATUS) ?
                   32'({phase_ff, slow_ff, oe_sync_ff, cfg_ff}) :
                   (rd_addr == ADDR_CONTROL) ? 32'(ctrl_dis_ff) :
                   (rd_addr == ADDR_CHAIN) ? 32'(chain_ff) : 32'h0;

  // write address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= '0;
      w_strb0_ff <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb0_ff <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
    end
  end

  // write response and control register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      ctrl_dis_ff <= 1'b0;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ctrl || ((aw_addr_ff & ADDR_MASK) == ADDR_STATUS) ||
                     ((aw_addr_ff & ADDR_MASK) == ADDR_CHAIN) ? RESP_OKAY : RESP_SLVERR;
      if (wr_ctrl && w_strb0_ff)
      begin
        ctrl_dis_ff <= w_data_ff[CTRL_DIS_BIT];
      end
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel, answer one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_disabled_levels;
    !gated |=> !synth_out_p && synth_out_n;
  endproperty
  a_disabled_levels: assert property (p_disabled_levels) else $error("disabled output levels wrong");

  property p_enable_at_low;
    $changed(oe_sync_ff) |-> !$past(phase_ff);
  endproperty
  a_enable_at_low: assert property (p_enable_at_low) else $error("enable changed in high phase");

  property p_shift_capture;
    shift_rise |=> chain_ff[0] == $past(pin_r.serial_config_in);
  endproperty
  a_shift_capture: assert property (p_shift_capture) else $error("shift chain missed data");

  property p_serial_follow;
    pin_r.serial_latch_strobe && pin_r.parallel_latch_strobe_n |=> cfg_ff == $past(chain_cfg);
  endproperty
  a_serial_follow: assert property (p_serial_follow) else $error("serial latch not transparent");

  property p_parallel_follow;
    !pin_r.parallel_latch_strobe_n |=> cfg_ff.loop_div == $past(pin_r.loop_divide_value) &&
      cfg_ff.div_sel == $past(pin_r.output_divide_select);
  endproperty
  a_parallel_follow: assert property (p_parallel_follow) else $error("parallel latch wrong");

  property p_hold;
    !pin_r.serial_latch_strobe && pin_r.parallel_latch_strobe_n |=> $stable(cfg_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("configuration changed without strobe");

  property p_ref_select;
    ##1 pll_reference_out == ($past(pin_r.reference_source_select) ?
      $past(pin_r.crystal_osc_pins) : $past(pin_r.external_reference_in));
  endproperty
  a_ref_select: assert property (p_ref_select) else $error("reference source wrong");

  property p_divide_by_one;
    aresetn && vco_tick && !slow_ff && cfg_ff.div_sel == ~DIV_CODE_2 |=> phase_ff != $past(phase_ff);
  endproperty
  a_divide_by_one: assert property (p_divide_by_one) else $error("divide by one missed");

  property p_slow_ratio;
    wrap && slow_ff && cfg_ff.div_sel == ~DIV_CODE_2 |-> edge_cnt_ff == CNT_W'(SLOW_FACTOR - CNT_ONE);
  endproperty
  a_slow_ratio: assert property (p_slow_ratio) else $error("slow wrap count wrong");

  property p_slow_limit;
    $changed(slow_ff) |-> $past(wrap);
  endproperty
  a_slow_limit: assert property (p_slow_limit) else $error("slow change off boundary");

  property p_diag_route;
    ##1 diagnostic_out == $past(diag_mux);
  endproperty
  a_diag_route: assert property (p_diag_route) else $error("diagnostic output wrong");

  property p_open_low;
    !pins_driven.serial_shift_clock |-> !pin_r.serial_shift_clock;
  endproperty
  a_open_low: assert property (p_open_low) else $error("open pin not low");

  property p_open_high;
    !pins_driven.output_drive_enable |-> pin_r.output_drive_enable;
  endproperty
  a_open_high: assert property (p_open_high) else $error("open pin not high");

  c_enable: cover property (!oe_sync_ff ##1 oe_sync_ff ##[1:300] synth_out_p);
  c_slow: cover property (!slow_ff ##1 slow_ff);
  c_serial_load: cover property (shift_rise ##[1:100] pin_r.serial_latch_strobe);
  c_axi_write: cover property (do_write && wr_ctrl);

endmodule // scl_synth_config

/* File: sim/scl_host_model.sv */
`timescale 1ns/1ps
// ==========================================================
// board logic on the configuration pins
module scl_host_model
  import scl_pkg::*;
(
  input wire logic aclk,
  output scl_pins_type pins,
  output scl_pins_type pins_driven
);
  scl_pins_type pin_ff;
  scl_pins_type drv_ff;

  // every line starts open at its pull level
  initial
  begin
    pin_ff = PULL_LEVEL;
    drv_ff = '0;
  end

  // an open line shows the inverse of its last level, the design applies the pull
  assign pins = pin_ff ^ ~drv_ff;
  assign pins_driven = drv_ff;

  // ==========================================================
  // pin sequences, each step just after a clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic set_ctl(input logic oe, sel, slow, ext, xtal);
    @(posedge aclk);
    pin_ff.output_drive_enable <= oe;
    pin_ff.reference_source_select <= sel;
    pin_ff.slow_output_request <= slow;
    pin_ff.external_reference_in <= ext;
    pin_ff.crystal_osc_pins <= xtal;
    drv_ff <= '1;
  endtask

  // lets the reference line or every line float
  task automatic open_pins(input logic ext_only);
    @(posedge aclk);
    if (ext_only)
      drv_ff.external_reference_in <= 1'b0;
    else
      drv_ff <= '0;
  endtask

  task automatic par_load(input logic [LOOP_W-1:0] lv, input logic [DIV_W-1:0] dv);
    @(posedge aclk);
    pin_ff.loop_divide_value <= lv;
    pin_ff.output_divide_select <= dv;
    pin_ff.parallel_latch_strobe_n <= 1'b0;
    drv_ff <= '1;
    tick(3);
    pin_ff.parallel_latch_strobe_n <= 1'b1;
    // values stay put across the rising strobe, then move away
    tick(2);
    pin_ff.loop_divide_value <= ~lv;
    pin_ff.output_divide_select <= ~dv;
  endtask

  // first bit sent lands in the top of the chain
  task automatic ser_shift(input logic [CHAIN_W-1:0] w);
    for (int i = CHAIN_W - 1; i >= 0; i--)
    begin
      @(posedge aclk);
      pin_ff.serial_config_in <= w[i];
      pin_ff.serial_shift_clock <= 1'b0;
      drv_ff <= '1;
      tick(2);
      pin_ff.serial_shift_clock <= 1'b1;
      tick(1);
    end
    @(posedge aclk);
    pin_ff.serial_shift_clock <= 1'b0;
  endtask

  task automatic ser_latch();
    @(posedge aclk);
    pin_ff.serial_latch_strobe <= 1'b1;
    tick(3);
    pin_ff.serial_latch_strobe <= 1'b0;
    // chain is left alone across the falling strobe
    tick(2);
  endtask
endmodule // scl_host_model

/* File: sim/synth_config_logic_tb.sv */
`timescale 1ns/1ps
module synth_config_logic_tb
  import scl_pkg::*;
;
  logic aclk;
  logic aresetn;
  logic vco_tick;
  scl_pins_type pins;
  scl_pins_type pins_driven;
  logic synth_out_p, synth_out_n, diagnostic_out, pll_reference_out;
  logic [LOOP_W-1:0] loop_divide_out;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] d;
  logic [1:0] r;
  int c;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;

  scl_host_model host (.aclk(aclk), .pins(pins), .pins_driven(pins_driven));

  scl_synth_config dut (
    .aclk(aclk), .aresetn(aresetn), .pins(pins), .pins_driven(pins_driven),
    .vco_tick(vco_tick), .synth_out_p(synth_out_p), .synth_out_n(synth_out_n),
    .diagnostic_out(diagnostic_out), .pll_reference_out(pll_reference_out),
    .loop_divide_out(loop_divide_out), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  // ==========================================================
  // clock, vco pulses every other cycle, hang guard
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
      vco_tick <= 1'b0;
    else
      vco_tick <= ~vco_tick;
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_count++;
      print_verdict();
    end
  end

  // ==========================================================
  // helpers
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // cycles that one high half of the true output lasts
  task half_per();
    c = 0;
    do @(posedge aclk); while (synth_out_p !== 1'b0);
    do @(posedge aclk); while (synth_out_p !== 1'b1);
    do
    begin
      @(posedge aclk);
      c++;
    end while (synth_out_p === 1'b1);
  endtask

  task off_chk();
    host.tick(12);
    repeat (8)
    begin
      @(posedge aclk);
      chk("out p off", 0, synth_out_p);
      chk("out n off", 1, synth_out_n);
    end
  endtask

  // ==========================================================
  // scenarios
  task t_reset();
    axi_rd(ADDR_STATUS);
    chk("status cfg", 32'h1ff, d & 32'hfff);
    chk("loop out", 32'h7f, loop_divide_out);
    half_per();
    chk("div1 half", 2, c);
    $display("test reset done");
  endtask

  task t_par();
    int half_tab [4] = '{2, 4, 8, 1};
    for (int k = 0; k < 4; k++)
    begin
      host.par_load(7'(8'h2a + k), 2'(k));
      host.tick(4);
      chk("loop out", 8'h2a + k, loop_divide_out);
      axi_rd(ADDR_STATUS);
      chk("status cfg", (k << 7) | (8'h2a + k), d & 32'hfff);
      half_per();
      half_per();
      chk("half period", 2 * half_tab[k], c);
    end
    $display("test parallel done");
  endtask

  task t_slow();
    host.set_ctl(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    half_per();
    half_per();
    chk("slow half", 32, c);
    host.set_ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    half_per();
    half_per();
    chk("normal half", 2, c);
    $display("test slow done");
  endtask

  task t_oe();
    host.set_ctl(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    off_chk();
    host.set_ctl(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    half_per();
    chk("first half", 2, c);
    axi_wr(ADDR_CONTROL, 32'h1);
    off_chk();
    axi_rd(ADDR_CONTROL);
    chk("ctl bit", 1, d & 32'h1);
    s_axi_wstrb <= 4'h0;
    axi_wr(ADDR_CONTROL, 32'h0);
    s_axi_wstrb <= 4'hf;
    axi_rd(ADDR_CONTROL);
    chk("ctl kept", 1, d & 32'h1);
    axi_wr(ADDR_CONTROL, 32'h0);
    $display("test enable done");
  endtask

  task t_ref();
    logic [4:0] tab [4] = '{5'h19, 5'h12, 5'h0a, 5'h01};
    for (int k = 0; k < 4; k++)
    begin
      host.set_ctl(1'b1, tab[k][3], 1'b0, tab[k][1], tab[k][0]);
      host.tick(4);
      chk("ref out", tab[k][4], pll_reference_out);
    end
    host.open_pins(1'b1);
    host.tick(4);
    chk("ref open", 0, pll_reference_out);
    $display("test reference done");
  endtask

  task t_ser();
    host.ser_shift(12'hb15);
    host.tick(2);
    axi_rd(ADDR_CHAIN);
    chk("chain", 32'hb15, d & 32'hfff);
    axi_rd(ADDR_STATUS);
    chk("cfg before latch", 32'h1ad, d & 32'hfff);
    host.ser_latch();
    host.tick(3);
    axi_rd(ADDR_STATUS);
    chk("cfg after latch", 32'hb15, d & 32'hfff);
    chk("diag high", 1, diagnostic_out);
    half_per();
    chk("div8 half", 16, c);
    host.ser_shift(12'h315);
    host.ser_latch();
    host.open_pins(1'b0);
    host.tick(6);
    chk("diag low", 0, diagnostic_out);
    axi_wr(ADDR_STATUS, 32'hfff);
    chk("ro write resp", RESP_OKAY, r);
    axi_rd(ADDR_STATUS);
    chk("cfg open pins", 32'h315, d & 32'hfff);
    host.ser_shift(12'h815);
    host.ser_latch();
    host.tick(2);
    chk("diag chain", 1, diagnostic_out);
    axi_rd(8'h0c);
    chk("bad rd resp", RESP_SLVERR, r);
    chk("bad rd data", 0, d);
    axi_wr(8'h0c, 32'h1);
    chk("bad wr resp", RESP_SLVERR, r);
    $display("test serial done");
  endtask

  task print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // main sequence after reset
  initial
  begin
    aresetn <= 1'b0;
    s_axi_awaddr <= '0;
    s_axi_araddr <= '0;
    s_axi_wdata <= '0;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_par();
    t_slow();
    t_oe();
    t_ref();
    t_ser();
    print_verdict();
  end
endmodule // synth_config_logic_tb
